//--- tb/wbf_mem_model.sv
// Purpose: External memory partner on the processor bus side
// Assumes: One word completes per BUS_READY pulse, latency lat+1 cycles
// Notes: Read data is built from the address so the bench can predict it
`timescale 1ns/1ps
`default_nettype none
module wbf_mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic hold,
  input wire logic [1:0] lat,
  input wire logic req,
  input wire logic [31:0] addr,
  output logic idle,
  output logic ready,
  output logic [31:0] rdata
);
  logic [1:0] cnt_r;
  ////////////////////////////////////////////////////////////
  // Bus is offered only while the bench is not holding it
  assign idle = !hold && !req;
  // Outside a beat the lines show the inverse, never the good word
  assign rdata = ready ? (addr ^ 32'hA5A5_0000) : ~(addr ^ 32'hA5A5_0000);
  always_ff @(posedge clk) begin
    if (reset || !req || ready) begin
      cnt_r <= 2'h0;
      ready <= 1'b0;
    end else if (cnt_r == lat) begin
      ready <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule // wbf_mem_model
`default_nettype wire

//--- tb/wbf_top_tb_top.sv
// Purpose: Self-checking bench for the write buffer and fill path
// Assumes: Inputs change at the falling edge
// Notes: Bus beats are logged as {write, address} in order
`timescale 1ns/1ps
`default_nettype none
module wbf_top_tb_top;
  typedef struct packed {logic hit; logic cach; logic [31:0] addr; logic [2:0] nb;} wbf_row_s;
  logic CLK, RESET, WR_VALID, WR_HIT, RD_VALID, RD_HIT, RD_CACHEABLE, RD_PF_SEL, hold;
  wbf_pkg::wbf_addr_t WR_ADDR, RD_ADDR, BUS_ADDR, CACHE_WR_ADDR, FILL_ADDR;
  wbf_pkg::wbf_data_t WR_DATA, RD_HIT_DATA, RD_DATA, BUS_RDATA, BUS_WDATA;
  wbf_pkg::wbf_data_t CACHE_WR_DATA, FILL_DATA, rd_seen;
  logic WR_READY, CACHE_WR, RD_READY, RD_DVALID, FILL_WR, BUS_IDLE, BUS_READY, BUS_REQ;
  logic BUS_WRITE;
  logic [1:0] PF_VALID, lat;
  logic [127:0] RD_HIT_LINE;
  logic [255:0] PF_DATA;
  logic [2:0] WB_COUNT;
  logic [32:0] bq[$];
  int n_mismatch, compares, beats, fills, dv_beat, k;
  wbf_row_s rows [4] = '{'{1'b1, 1'b0, 32'h0000_0100, 3'h0}, '{1'b0, 1'b1, 32'h0000_0200, 3'h4},
                         '{1'b0, 1'b1, 32'h0000_0308, 3'h4}, '{1'b0, 1'b0, 32'h0000_0404, 3'h1}};
  wbf_top i_dut (.CLK, .RESET, .WR_VALID, .WR_ADDR, .WR_DATA, .WR_HIT, .WR_READY, .CACHE_WR,
    .CACHE_WR_ADDR, .CACHE_WR_DATA, .RD_VALID, .RD_ADDR, .RD_HIT, .RD_HIT_DATA, .RD_CACHEABLE,
    .RD_PF_SEL, .RD_HIT_LINE, .RD_READY, .RD_DVALID, .RD_DATA, .FILL_WR, .FILL_ADDR, .FILL_DATA,
    .PF_VALID, .PF_DATA, .BUS_IDLE, .BUS_READY, .BUS_RDATA, .BUS_REQ, .BUS_WRITE, .BUS_ADDR,
    .BUS_WDATA, .WB_COUNT);
  wbf_mem_model i_mem (.clk(CLK), .reset(RESET), .hold(hold), .lat(lat), .req(BUS_REQ),
    .addr(BUS_ADDR), .idle(BUS_IDLE), .ready(BUS_READY), .rdata(BUS_RDATA));
  always #2.5 CLK = ~CLK;
  ////////////////////////////////////////////////////////////
  always @(posedge CLK) begin
    if (BUS_REQ && BUS_READY) begin
      bq.push_back({BUS_WRITE, BUS_ADDR});
      beats++;
    end
    if (BUS_REQ && BUS_READY && BUS_WRITE) chk("bus_wdata", {~BUS_ADDR}, BUS_WDATA);
    if (FILL_WR) chk("fill_word", FILL_ADDR ^ 32'hA5A5_0000, FILL_DATA);
    if (FILL_WR) fills++;
    if (RD_DVALID) begin
      rd_seen = RD_DATA;
      dv_beat = beats;
    end
  end
  task automatic chk(input string what, input logic [159:0] exp, input logic [159:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Line as the memory partner returns it, word w at bits 32*w
  function automatic logic [127:0] pf_line(input logic [31:0] a);
    for (int w = 0; w < 4; w++) pf_line[32*w +: 32] = {a[31:4], 2'(w), 2'h0} ^ 32'hA5A5_0000;
  endfunction
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic timeout;
    chk("wait_bound", 1, 0);
    tally_and_finish();
  endtask
  // Leaves WR_VALID high so the next call can follow back to back
  task automatic wr_put(input logic [31:0] a, input logic h);
    int i;
    WR_VALID = 1'b1;
    WR_ADDR = a;
    WR_DATA = ~a;
    WR_HIT = h;
    #1;
    for (i = 0; WR_READY !== 1'b1; i++) begin
      if (i == 200) timeout();
      @(negedge CLK);
      #1;
    end
    chk("cache_wr", h, CACHE_WR);
    chk("cache_wr_word", {a, ~a}, {CACHE_WR_ADDR, CACHE_WR_DATA});
    @(negedge CLK);
  endtask
  task automatic rd_do(input logic [31:0] a, input logic h, input logic c, input logic s);
    int i;
    beats = 0;
    fills = 0;
    dv_beat = -1;
    RD_VALID = 1'b1;
    RD_ADDR = a;
    RD_HIT = h;
    RD_CACHEABLE = c;
    RD_PF_SEL = s;
    RD_HIT_DATA = ~a;
    #1;
    for (i = 0; RD_READY !== 1'b1; i++) begin
      if (i == 200) timeout();
      @(negedge CLK);
      #1;
    end
    @(negedge CLK);
    RD_VALID = 1'b0;
    repeat (3) @(negedge CLK);
  endtask
  task automatic wait_quiet;
    int i;
    for (i = 0; WB_COUNT !== 3'h0 || BUS_REQ !== 1'b0; i++) begin
      if (i == 200) timeout();
      @(negedge CLK);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {CLK, WR_VALID, WR_HIT, RD_VALID, RD_HIT, RD_CACHEABLE, RD_PF_SEL, hold} = 8'h00;
    {WR_ADDR, WR_DATA, RD_ADDR, RD_HIT_DATA} = 128'h0;
    RD_HIT_LINE = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    RESET = 1'b1;
    lat = 2'h1;
    repeat (6) @(negedge CLK);
    chk("reset_outputs", 7'h00, {BUS_REQ, WB_COUNT, PF_VALID, RD_DVALID});
    RESET = 1'b0;
    @(negedge CLK);
    foreach (rows[r]) begin
      rd_do(rows[r].addr, rows[r].hit, rows[r].cach, 1'b0);
      chk("rd_beats", rows[r].nb, beats);
      chk("fill_beats", rows[r].cach ? 4 : 0, fills);
      chk("rd_data", rows[r].hit ? {~rows[r].addr} : rows[r].addr ^ 32'hA5A5_0000, rd_seen);
      chk("first_word_early", rows[r].hit ? 0 : 1, dv_beat);
      chk("pf0_valid", rows[r].hit || rows[r].cach, PF_VALID[0]);
      if (rows[r].cach) chk("pf0_line", pf_line(rows[r].addr), PF_DATA[127:0]);
    end
    // Back-to-back hits, prefetch buffer 1 loaded from the cache line
    RD_VALID = 1'b1;
    RD_HIT = 1'b1;
    RD_PF_SEL = 1'b1;
    for (k = 0; k < 3; k++) begin
      RD_ADDR = 32'h0000_7000 + 32'(4 * k);
      RD_HIT_DATA = ~RD_ADDR;
      #1;
      chk("rd_ready_hit", 1, RD_READY);
      @(negedge CLK);
      chk("rd_dvalid_hit", 1, RD_DVALID);
      chk("rd_data_hit", {~RD_ADDR}, RD_DATA);
    end
    chk("pf_cache_fill", {1'b1, RD_HIT_LINE}, {PF_VALID[1], PF_DATA[255:128]});
    RD_VALID = 1'b0;
    wr_put(32'h0000_1000, 1'b0);
    chk("bypass", {1'b1, 1'b1, 3'h0, 32'h0000_1000}, {BUS_REQ, BUS_WRITE, WB_COUNT, BUS_ADDR});
    WR_VALID = 1'b0;
    wait_quiet();
    hold = 1'b1;
    bq.delete();
    for (k = 0; k < 4; k++) wr_put(32'h0000_2000 + 32'(4 * k), 1'b0);
    chk("wb_count_full", 3'h4, WB_COUNT);
    WR_ADDR = 32'h0000_2010;
    #1;
    chk("full_refused", 2'h0, {WR_READY, BUS_REQ});
    @(negedge CLK);
    hold = 1'b0;
    wr_put(32'h0000_2010, 1'b0);
    WR_VALID = 1'b0;
    wait_quiet();
    for (k = 0; k < 5; k++) chk("wr_order", {1'b1, 32'h0000_2000 + 32'(4 * k)}, bq[k]);
    hold = 1'b1;
    wr_put(32'h0000_3000, 1'b1);
    wr_put(32'h0000_3004, 1'b1);
    WR_VALID = 1'b0;
    bq.delete();
    hold = 1'b0;
    rd_do(32'h0000_4000, 1'b0, 1'b0, 1'b0);
    wait_quiet();
    chk("read_first", {1'b0, 32'h0000_4000}, bq[0]);
    chk("hits_retired", 3, bq.size());
    hold = 1'b1;
    wr_put(32'h0000_5000, 1'b0);
    WR_VALID = 1'b0;
    bq.delete();
    hold = 1'b0;
    rd_do(32'h0000_6000, 1'b0, 1'b0, 1'b0);
    chk("write_first", {1'b1, 32'h0000_5000}, bq[0]);
    // Reset in mid-run drops the held write and empties both prefetch buffers
    hold = 1'b1;
    wr_put(32'h0000_7100, 1'b0);
    WR_VALID = 1'b0;
    RESET = 1'b1;
    @(negedge CLK);
    RESET = 1'b0;
    bq.delete();
    hold = 1'b0;
    chk("reset_mid", 5'h00, {BUS_REQ, WB_COUNT, PF_VALID});
    repeat (6) @(negedge CLK);
    chk("reset_flush", 0, bq.size());
    tally_and_finish();
  end
endmodule // wbf_top_tb_top
`default_nettype wire

//--- verilog/wbf_cfg.svh
// Purpose: Constants for the write buffer and fill path
// Assumes: Included by the package and design files
// Notes: Timing counts are in cycles of CLK
// Notes on behaviour
// - Exactly four posted write entries
// - At most one new entry per cycle
// - Empty buffer, idle bus: write bypasses
// - Bus busy: hold write, issue later
// - Cache write hit updates line immediately
// - Buffered writes retire in FIFO order
// - Read passes writes only if all hit
// - Every write goes to the bus
// - Read miss uses bus, hit stays internal
// - Cache hit returns data every cycle
// - Two independent 128-bit prefetch buffers
// - Prefetch fill: one cycle cache, four external
// - First fill word forwarded to requester
// - Cacheable miss four words, else one
`ifndef WBF_CFG_SVH
`define WBF_CFG_SVH
`define WBF_DEPTH 4
`define WBF_PTR_W 2
`define WBF_CNT_W 3
`define WBF_AW 32
`define WBF_DW 32
`define WBF_LINE_WORDS 3'h4
`define WBF_PF_W 128
`define WBF_PF_N 2
`define WBF_WORD_OFS 2
`endif

//--- verilog/wbf_pkg.sv
// Purpose: Types for the write buffer and fill path
// Assumes: wbf_cfg.svh holds the numbers
// Notes: Bus sequencer states plus the address and data word types
`include "wbf_cfg.svh"
package wbf_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10
  } wbf_state_e;
  typedef logic [`WBF_AW-1:0] wbf_addr_t;
  typedef logic [`WBF_DW-1:0] wbf_data_t;
endpackage

//--- verilog/wbf_prefetch.sv
// Purpose: One 128-bit prefetch buffer
// Assumes: Cache line arrives whole, bus words arrive once each in any wrap order
// Notes: Valid only once all four words are present
`timescale 1ns/1ps
`default_nettype none
`include "wbf_cfg.svh"
module wbf_prefetch (
  input wire logic clk,
  input wire logic reset,
  input wire logic line_load,
  input wire logic [`WBF_PF_W-1:0] line_data,
  input wire logic word_load,
  input wire logic [1:0] word_idx,
  input wire logic [`WBF_DW-1:0] word_data,
  input wire logic invalidate,
  output logic valid,
  output logic [`WBF_PF_W-1:0] data
);
  logic [`WBF_PF_W-1:0] data_r;
  logic valid_r;
  logic [`WBF_CNT_W-1:0] words_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      data_r <= '0;
    end else if (line_load) begin
      data_r <= line_data;
    end else if (word_load) begin
      data_r[word_idx*`WBF_DW +: `WBF_DW] <= word_data;
    end
  end
  // Words counted, not indexed, so a fill that wraps mid-line still completes
  always_ff @(posedge clk) begin
    if (reset || invalidate || line_load) begin
      words_r <= '0;
    end else if (word_load) begin
      words_r <= words_r + `WBF_CNT_W'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (reset || invalidate) begin
      valid_r <= 1'b0;
    end else if (line_load) begin
      valid_r <= 1'b1;
    end else if (word_load) begin
      valid_r <= (words_r + `WBF_CNT_W'(1) == `WBF_LINE_WORDS);
    end
  end
  assign valid = valid_r;
  assign data = data_r;
endmodule // wbf_prefetch
`default_nettype wire

//--- verilog/wbf_top.sv
// Purpose: Posted write buffer, read ordering and line fill forwarding
// Assumes: Bus grants one cycle per word on BUS_READY; cache lookups given as hit inputs
// Notes: The cache array itself is outside; this block drives its update strobes
`timescale 1ns/1ps
`default_nettype none
`include "wbf_cfg.svh"
module wbf_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic WR_VALID,
  input wire wbf_pkg::wbf_addr_t WR_ADDR,
  input wire wbf_pkg::wbf_data_t WR_DATA,
  input wire logic WR_HIT,
  output logic WR_READY,
  output logic CACHE_WR,
  output wbf_pkg::wbf_addr_t CACHE_WR_ADDR,
  output wbf_pkg::wbf_data_t CACHE_WR_DATA,
  input wire logic RD_VALID,
  input wire wbf_pkg::wbf_addr_t RD_ADDR,
  input wire logic RD_HIT,
  input wire wbf_pkg::wbf_data_t RD_HIT_DATA,
  input wire logic RD_CACHEABLE,
  input wire logic RD_PF_SEL,
  input wire logic [`WBF_PF_W-1:0] RD_HIT_LINE,
  output logic RD_READY,
  output logic RD_DVALID,
  output wbf_pkg::wbf_data_t RD_DATA,
  output logic FILL_WR,
  output wbf_pkg::wbf_addr_t FILL_ADDR,
  output wbf_pkg::wbf_data_t FILL_DATA,
  output logic [`WBF_PF_N-1:0] PF_VALID,
  output logic [`WBF_PF_N*`WBF_PF_W-1:0] PF_DATA,
  input wire logic BUS_IDLE,
  input wire logic BUS_READY,
  input wire wbf_pkg::wbf_data_t BUS_RDATA,
  output logic BUS_REQ,
  output logic BUS_WRITE,
  output wbf_pkg::wbf_addr_t BUS_ADDR,
  output wbf_pkg::wbf_data_t BUS_WDATA,
  output logic [`WBF_CNT_W-1:0] WB_COUNT
);
  ////////////////////////////////////////////////////////////////////////////
  // four entries
  wbf_pkg::wbf_addr_t addr_mem [`WBF_DEPTH];
  wbf_pkg::wbf_data_t data_mem [`WBF_DEPTH];
  logic hit_mem [`WBF_DEPTH];
  logic [`WBF_PTR_W-1:0] rd_ptr_r;
  logic [`WBF_PTR_W-1:0] wr_ptr_r;
  logic [`WBF_CNT_W-1:0] count_r;
  wbf_pkg::wbf_state_e state_r;
  logic [1:0] beat_r;
  logic [1:0] last_beat_r;
  logic bypass_r;
  logic rd_pf_r;
  logic rd_cacheable_r;
  wbf_pkg::wbf_addr_t rd_addr_r;
  logic [`WBF_DW-1:0] bus_addr_r;
  logic [`WBF_DW-1:0] bus_wdata_r;
  logic bus_req_r;
  logic bus_write_r;
  logic rd_dvalid_r;
  wbf_pkg::wbf_data_t rd_data_r;
  logic all_hit;
  logic buf_empty;
  logic buf_full;
  logic do_bypass;
  logic push;
  logic pop;
  logic rd_start;
  logic rd_miss_req;
  logic rd_done;
  logic wr_done;

  function automatic logic [1:0] word_of(input wbf_pkg::wbf_addr_t a);
    word_of = a[`WBF_WORD_OFS +: 2];
  endfunction

  assign buf_empty = (count_r == '0);
  assign buf_full = (count_r == `WBF_CNT_W'(`WBF_DEPTH));
  // all pending writes are cache hits
  always_comb begin
    all_hit = 1'b1;
    for (int i = 0; i < `WBF_DEPTH; i++) begin
      if (i < count_r && !hit_mem[`WBF_PTR_W'(rd_ptr_r + `WBF_PTR_W'(i))]) begin
        all_hit = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bypass when empty and bus idle
  assign do_bypass = WR_VALID && buf_empty && BUS_IDLE && state_r == wbf_pkg::ST_IDLE;
  assign WR_READY = !buf_full || do_bypass;
  // one entry per cycle; hold while bus busy
  assign push = WR_VALID && !buf_full && !do_bypass;
  assign rd_miss_req = RD_VALID && !RD_HIT;
  assign rd_start = rd_miss_req && state_r == wbf_pkg::ST_IDLE && !do_bypass && BUS_IDLE
                    && (buf_empty || all_hit);
  assign pop = state_r == wbf_pkg::ST_IDLE && !buf_empty && BUS_IDLE && !rd_start;
  assign rd_done = state_r == wbf_pkg::ST_READ && BUS_READY && beat_r == last_beat_r;
  assign wr_done = state_r == wbf_pkg::ST_WRITE && BUS_READY;
  // hits served without bus; every cycle
  assign RD_READY = RD_HIT || rd_done;

  // cache update at once on hit
  assign CACHE_WR = WR_VALID && WR_READY && WR_HIT;
  assign CACHE_WR_ADDR = WR_ADDR;
  assign CACHE_WR_DATA = WR_DATA;

  always_ff @(posedge CLK) begin
    if (push) begin
      addr_mem[wr_ptr_r] <= WR_ADDR;
      data_mem[wr_ptr_r] <= WR_DATA;
      hit_mem[wr_ptr_r] <= WR_HIT;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_ptr_r <= '0;
      wr_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 2'h1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 2'h1;
      end
      count_r <= count_r + `WBF_CNT_W'(push) - `WBF_CNT_W'(pop);
    end
  end
  assign WB_COUNT = count_r;

  ////////////////////////////////////////////////////////////////////////////
  // every write reaches the bus
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r <= wbf_pkg::ST_IDLE;
      bus_req_r <= 1'b0;
      bus_write_r <= 1'b0;
      bus_addr_r <= '0;
      bus_wdata_r <= '0;
      bypass_r <= 1'b0;
      beat_r <= '0;
      last_beat_r <= '0;
    end else begin
      unique case (state_r)
        wbf_pkg::ST_IDLE: begin
          if (do_bypass) begin
            state_r <= wbf_pkg::ST_WRITE;
            bus_req_r <= 1'b1;
            bus_write_r <= 1'b1;
            bus_addr_r <= WR_ADDR;
            bus_wdata_r <= WR_DATA;
            bypass_r <= 1'b1;
          end else if (rd_start) begin
            state_r <= wbf_pkg::ST_READ;
            bus_req_r <= 1'b1;
            bus_write_r <= 1'b0;
            bus_addr_r <= RD_ADDR;
            beat_r <= word_of(RD_ADDR);
            last_beat_r <= RD_CACHEABLE ? word_of(RD_ADDR) - 2'h1 : word_of(RD_ADDR);
          end else if (pop) begin
            state_r <= wbf_pkg::ST_WRITE;
            bus_req_r <= 1'b1;
            bus_write_r <= 1'b1;
            bus_addr_r <= addr_mem[rd_ptr_r];
            bus_wdata_r <= data_mem[rd_ptr_r];
            bypass_r <= 1'b0;
          end
        end
        wbf_pkg::ST_WRITE: begin
          if (wr_done) begin
            state_r <= wbf_pkg::ST_IDLE;
            bus_req_r <= 1'b0;
          end
        end
        wbf_pkg::ST_READ: begin
          if (BUS_READY) begin
            beat_r <= beat_r + 2'h1;
            bus_addr_r[`WBF_WORD_OFS +: 2] <= beat_r + 2'h1;
            if (rd_done) begin
              state_r <= wbf_pkg::ST_IDLE;
              bus_req_r <= 1'b0;
            end
          end
        end
        default: begin
          state_r <= wbf_pkg::ST_IDLE;
          bus_req_r <= 1'b0;
        end
      endcase
    end
  end
  assign BUS_REQ = bus_req_r;
  assign BUS_WRITE = bus_write_r;
  assign BUS_ADDR = bus_addr_r;
  assign BUS_WDATA = bus_wdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read request latches for the fill
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_pf_r <= 1'b0;
      rd_cacheable_r <= 1'b0;
      rd_addr_r <= '0;
    end else if (rd_start) begin
      rd_pf_r <= RD_PF_SEL;
      rd_cacheable_r <= RD_CACHEABLE;
      rd_addr_r <= RD_ADDR;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_dvalid_r <= 1'b0;
      rd_data_r <= '0;
    end else if (RD_VALID && RD_HIT) begin
      rd_dvalid_r <= 1'b1;
      rd_data_r <= RD_HIT_DATA;
    end else if (state_r == wbf_pkg::ST_READ && BUS_READY && beat_r == word_of(rd_addr_r)) begin
      rd_dvalid_r <= 1'b1;
      rd_data_r <= BUS_RDATA;
    end else begin
      rd_dvalid_r <= 1'b0;
    end
  end
  assign RD_DVALID = rd_dvalid_r;
  assign RD_DATA = rd_data_r;

  assign FILL_WR = state_r == wbf_pkg::ST_READ && BUS_READY && rd_cacheable_r;
  assign FILL_ADDR = {rd_addr_r[`WBF_AW-1:`WBF_WORD_OFS+2], beat_r, 2'h0};
  assign FILL_DATA = BUS_RDATA;

  ////////////////////////////////////////////////////////////////////////////
  // two independent prefetch buffers
  for (genvar g = 0; g < `WBF_PF_N; g++) begin : g_pf
    wbf_prefetch u_pf (
      .clk(CLK),
      .reset(RESET),
      .line_load(RD_VALID && RD_HIT && RD_PF_SEL == g[0]),
      .line_data(RD_HIT_LINE),
      .word_load(FILL_WR && rd_pf_r == g[0]),
      .word_idx(beat_r),
      .word_data(BUS_RDATA),
      .invalidate(rd_start && RD_PF_SEL == g[0]),
      .valid(PF_VALID[g]),
      .data(PF_DATA[g*`WBF_PF_W +: `WBF_PF_W])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // read may not pass a missing write
  AST_READ_ORDER: assert property (@(posedge CLK) disable iff (RESET)
    $rose(BUS_REQ) && !BUS_WRITE |-> $past(buf_empty || all_hit))
    else $error("Read passed a pending miss write");
  AST_FULL_STALL: assert property (@(posedge CLK) disable iff (RESET)
    WB_COUNT == 3'h4 |-> !WR_READY) else $error("Write accepted while full");
  AST_DEPTH: assert property (@(posedge CLK) disable iff (RESET)
    count_r <= `WBF_CNT_W'(`WBF_DEPTH)) else $error("Buffer over depth");
  // popped entry goes to bus next cycle
  AST_FIFO_ORDER: assert property (@(posedge CLK) disable iff (RESET)
    pop |=> BUS_WRITE && BUS_REQ && BUS_ADDR == $past(addr_mem[rd_ptr_r]))
    else $error("Buffered write out of order");
  // bypass starts bus write without buffering
  AST_BYPASS: assert property (@(posedge CLK) disable iff (RESET)
    do_bypass |=> BUS_REQ && BUS_WRITE && WB_COUNT == 3'h0) else $error("Bypass failed");
  AST_HIT_NO_BUS: assert property (@(posedge CLK) disable iff (RESET)
    RD_VALID && RD_HIT && state_r == wbf_pkg::ST_IDLE |-> RD_READY ##1 (!BUS_REQ || BUS_WRITE))
    else $error("Hit read used the bus");
  AST_SINGLE_BEAT: assert property (@(posedge CLK) disable iff (RESET)
    state_r == wbf_pkg::ST_READ && !rd_cacheable_r && BUS_READY |=> !BUS_REQ)
    else $error("Extra beat");
  // busy bus holds write in buffer
  AST_HOLD: assert property (@(posedge CLK) disable iff (RESET)
    WR_VALID && WR_READY && !BUS_IDLE |=> WB_COUNT != 3'h0) else $error("Write lost");
endmodule // wbf_top
`default_nettype wire
